// file: hw/sld_cfg.svh
// Constants for the front-panel status indicator driver.
// Summary of operation
// - After reset the power LED is solid red for about two seconds.
// - Then the power LED holds orange for about twelve seconds.
// - Then it alternates red and green quickly for about thirty seconds.
// - Then it flashes slowly for about fifty seconds.
// - After the boot pattern a healthy system shows steady green.
// - Boot phase durations come from parameters, not fixed constants.
// - Any flagged system fault drives the power LED red.
// - With radio link the radio LED is green, blinking off per reception.
// - Without link it is off, blinking green per reception, orange per transmit.
// - Serial LEDs: transmit green, receive red, both orange on RS-232.
// - A digital channel used as input lights orange while the input is on.
// - A digital channel used as output lights while the output is on.
// - Failed update with fail-safe on flashes orange mostly on.
// - Failed update with fail-safe off flashes orange mostly off.
// - Positive-side analog LED shows current-measuring mode.
// - Negative-side analog LED shows voltage-measuring mode.
// - Analog input LEDs light only while a signal is present.
// - Ethernet speed LED is green at 100 Mbps, off at 10 Mbps.
// - Ethernet link LED is orange while a connection exists.
// - Ethernet link LED blinks off briefly on each traffic event.
`ifndef SLD_CFG_SVH
`define SLD_CFG_SVH

`define SLD_CLK_NS          5
`define SLD_TICK_NS         1000000
`define SLD_RED_MS          2000
`define SLD_ORANGE_MS       12000
`define SLD_FAST_MS         30000
`define SLD_SLOW_MS         50000
`define SLD_FAST_PER_MS     250
`define SLD_SLOW_PER_MS     1000
`define SLD_DUTY_PCT        80
`define SLD_STRETCH_MS      50

`define SLD_ADDR_W          12
`define SLD_REG_CTRL        12'h000
`define SLD_REG_STATUS      12'h004
`define SLD_CTRL_DIR_LSB    0
`define SLD_CTRL_FS_LSB     8
`define SLD_CTRL_RST        32'h0000_0000

`endif

// file: hw/sld_pkg.sv
// Types shared by the status indicator driver.
package sld_pkg;

	typedef enum logic [4:0] {
		BOOT_RED    = 5'b00001,
		BOOT_ORANGE = 5'b00010,
		BOOT_FAST   = 5'b00100,
		BOOT_SLOW   = 5'b01000,
		BOOT_RUN    = 5'b10000
	} sld_boot_t;

	typedef enum logic [1:0] {
		COL_OFF = 2'h0,
		COL_RED = 2'h1,
		COL_GRN = 2'h2,
		COL_ORG = 2'h3
	} sld_colour_t;

	// Bit 1 is the green die, bit 0 the red die; orange lights both.
	function automatic logic [1:0] sld_dies(input sld_colour_t col);
		sld_dies = {col[1], col[0]};
	endfunction

endpackage

// file: hw/sld_stretch.sv
// Stretches single-cycle activity pulses to a visible length.
`timescale 1ns/1ps
`include "sld_cfg.svh"
module sld_stretch import sld_pkg::*; #(
	parameter int unsigned N       = 7,
	parameter int unsigned HOLD_MS = `SLD_STRETCH_MS
)(
	input  wire logic         i_clk_sys,
	input  wire logic         i_rst_n,
	input  wire logic         i_tick,
	input  wire logic [N-1:0] i_pulse,
	output logic      [N-1:0] o_active
);

	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_ch
			logic [15:0] cnt;

			// A pulse reloads the hold time; ticks count it down.
			always_ff @(posedge i_clk_sys or negedge i_rst_n)
			begin
				if (!i_rst_n)
					cnt <= 16'h0;
				else if (i_pulse[g])
					cnt <= 16'(HOLD_MS);
				else if (i_tick && cnt != 16'h0)
					cnt <= cnt - 16'h1;
			end

			always_ff @(posedge i_clk_sys or negedge i_rst_n)
			begin
				if (!i_rst_n)
					o_active[g] <= 1'b0;
				else
					o_active[g] <= i_pulse[g] || (cnt > 16'h1)
						|| (cnt == 16'h1 && !i_tick);
			end
		end
	endgenerate

endmodule

// file: hw/sld_top.sv
// Front-panel status indicator driver with APB configuration registers.
`timescale 1ns/1ps
`include "sld_cfg.svh"
module sld_top import sld_pkg::*; #(
	parameter int unsigned TICK_CYC    = `SLD_TICK_NS / `SLD_CLK_NS,
	parameter int unsigned RED_MS      = `SLD_RED_MS,
	parameter int unsigned ORANGE_MS   = `SLD_ORANGE_MS,
	parameter int unsigned FAST_MS     = `SLD_FAST_MS,
	parameter int unsigned SLOW_MS     = `SLD_SLOW_MS,
	parameter int unsigned FAST_PER_MS = `SLD_FAST_PER_MS,
	parameter int unsigned SLOW_PER_MS = `SLD_SLOW_PER_MS,
	parameter int unsigned DUTY_PCT    = `SLD_DUTY_PCT,
	parameter int unsigned STRETCH_MS  = `SLD_STRETCH_MS
)(
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_rst_n,
	input  wire logic                  i_psel,
	input  wire logic                  i_penable,
	input  wire logic                  i_pwrite,
	input  wire logic [`SLD_ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]           i_pwdata,
	output logic                       o_pready,
	output logic [31:0]                o_prdata,
	output logic                       o_pslverr,
	input  wire logic                  i_sys_fault,
	input  wire logic                  i_sys_healthy,
	input  wire logic                  i_radio_link,
	input  wire logic                  i_radio_rx,
	input  wire logic                  i_radio_tx,
	input  wire logic                  i_s232_tx,
	input  wire logic                  i_s232_rx,
	input  wire logic                  i_s485_tx,
	input  wire logic                  i_s485_rx,
	input  wire logic [7:0]            i_digital_channel_in,
	input  wire logic [7:0]            i_digital_channel_out,
	input  wire logic [7:0]            i_digital_channel_fail,
	input  wire logic [3:0]            i_ai_present,
	input  wire logic [1:0]            i_ai_current_mode,
	input  wire logic                  i_eth_link,
	input  wire logic                  i_eth_100m,
	input  wire logic                  i_eth_act,
	output logic [1:0]                 o_power_status_led,
	output logic [1:0]                 o_radio_link_led,
	output logic [1:0]                 o_s232_led,
	output logic [1:0]                 o_s485_led,
	output logic [7:0]                 o_digital_channel_led_red,
	output logic [7:0]                 o_digital_channel_led_grn,
	output logic [1:0]                 o_analog_input_led_pos,
	output logic [1:0]                 o_analog_input_led_neg,
	output logic [1:0]                 o_analog_input_led_se,
	output logic                       o_eth_speed_led,
	output logic                       o_eth_link_led
);

	localparam int unsigned FAST_HALF = FAST_PER_MS / 2;
	localparam int unsigned SLOW_HALF = SLOW_PER_MS / 2;
	localparam int unsigned LONG_ON   = SLOW_PER_MS * DUTY_PCT / 100;
	localparam int unsigned LONG_OFF  = SLOW_PER_MS * (100 - DUTY_PCT) / 100;

	logic [31:0] div_cnt;
	logic        tick;
	sld_boot_t   boot;
	sld_boot_t   next_boot;
	logic [31:0] phase_ms;
	logic        phase_done;
	logic [31:0] fast_ms;
	logic [31:0] slow_ms;
	logic        fast_on;
	logic        slow_on;
	logic        long_on;
	logic        long_off;
	logic [7:0]  dio_dir;
	logic [7:0]  dio_fs;
	logic [6:0]  act;
	logic        act_radio_rx;
	logic        act_radio_tx;
	logic        act_232_tx;
	logic        act_232_rx;
	logic        act_485_tx;
	logic        act_485_rx;
	logic        act_eth;
	logic        setup;
	sld_colour_t pwr_col;
	sld_colour_t radio_col;
	sld_colour_t s232_col;
	sld_colour_t s485_col;

	// One millisecond tick from the system clock.
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			div_cnt <= 32'h0;
		else if (div_cnt == 32'(TICK_CYC - 1))
			div_cnt <= 32'h0;
		else
			div_cnt <= div_cnt + 32'h1;
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			tick <= 1'b0;
		else
			tick <= (div_cnt == 32'(TICK_CYC - 1));
	end

	// Boot pattern sequencer; reset always restarts it at the red phase.
	always_comb
	begin
		phase_done = 1'b0;
		unique case (boot)
			BOOT_RED:    phase_done = (phase_ms == 32'(RED_MS - 1));
			BOOT_ORANGE: phase_done = (phase_ms == 32'(ORANGE_MS - 1));
			BOOT_FAST:   phase_done = (phase_ms == 32'(FAST_MS - 1));
			BOOT_SLOW:   phase_done = (phase_ms == 32'(SLOW_MS - 1));
			BOOT_RUN:    phase_done = 1'b0;
			default:     phase_done = 1'b1;
		endcase
	end

	always_comb
	begin
		next_boot = boot;
		if (tick && phase_done)
		begin
			unique case (boot)
				BOOT_RED:    next_boot = BOOT_ORANGE;
				BOOT_ORANGE: next_boot = BOOT_FAST;
				BOOT_FAST:   next_boot = BOOT_SLOW;
				BOOT_SLOW:   next_boot = BOOT_RUN;
				BOOT_RUN:    next_boot = BOOT_RUN;
				default:     next_boot = BOOT_RED;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			boot <= BOOT_RED;
		else
			boot <= next_boot;
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			phase_ms <= 32'h0;
		else if (tick && phase_done)
			phase_ms <= 32'h0;
		else if (tick && boot != BOOT_RUN)
			phase_ms <= phase_ms + 32'h1;
	end

	// Free-running flash timebases in milliseconds.
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			fast_ms <= 32'h0;
		else if (tick && fast_ms == 32'(FAST_PER_MS - 1))
			fast_ms <= 32'h0;
		else if (tick)
			fast_ms <= fast_ms + 32'h1;
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			slow_ms <= 32'h0;
		else if (tick && slow_ms == 32'(SLOW_PER_MS - 1))
			slow_ms <= 32'h0;
		else if (tick)
			slow_ms <= slow_ms + 32'h1;
	end

	assign fast_on  = (fast_ms < 32'(FAST_HALF));
	assign slow_on  = (slow_ms < 32'(SLOW_HALF));
	assign long_on  = (slow_ms < 32'(LONG_ON));
	assign long_off = (slow_ms < 32'(LONG_OFF));

	// Activity pulses held long enough to be seen.
	assign act = {i_eth_act, i_s485_rx, i_s485_tx, i_s232_rx, i_s232_tx,
		i_radio_tx, i_radio_rx};

	sld_stretch #(
		.N       (7),
		.HOLD_MS (STRETCH_MS)
	) u_stretch (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_tick    (tick),
		.i_pulse   (act),
		.o_active  ({act_eth, act_485_rx, act_485_tx, act_232_rx,
			act_232_tx, act_radio_tx, act_radio_rx})
	);

	// APB slave: one wait-free access phase, registered answer.
	assign setup = i_psel && !i_penable && !o_pready;

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_pready <= 1'b0;
		else
			o_pready <= setup;
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_pslverr <= 1'b0;
		else if (setup)
			o_pslverr <= (i_paddr != `SLD_REG_CTRL)
				&& (i_paddr != `SLD_REG_STATUS || i_pwrite);
		else
			o_pslverr <= 1'b0;
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_prdata <= 32'h0;
		else if (setup && !i_pwrite && i_paddr == `SLD_REG_CTRL)
			o_prdata <= {16'h0, dio_fs, dio_dir};
		else if (setup && !i_pwrite && i_paddr == `SLD_REG_STATUS)
			o_prdata <= {27'h0, boot};
		else
			o_prdata <= 32'h0;
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			dio_dir <= 8'(`SLD_CTRL_RST >> `SLD_CTRL_DIR_LSB);
			dio_fs  <= 8'(`SLD_CTRL_RST >> `SLD_CTRL_FS_LSB);
		end
		else if (i_psel && i_penable && o_pready && i_pwrite
			&& i_paddr == `SLD_REG_CTRL)
		begin
			dio_dir <= i_pwdata[`SLD_CTRL_DIR_LSB +: 8];
			dio_fs  <= i_pwdata[`SLD_CTRL_FS_LSB +: 8];
		end
	end

	// Power LED colour: fault first, then boot phase, then health.
	always_comb
	begin
		pwr_col = COL_RED;
		if (i_sys_fault)
			pwr_col = COL_RED;
		else
		begin
			unique case (boot)
				BOOT_RED:    pwr_col = COL_RED;
				BOOT_ORANGE: pwr_col = COL_ORG;
				BOOT_FAST:   pwr_col = fast_on ? COL_RED : COL_GRN;
				BOOT_SLOW:   pwr_col = slow_on ? COL_GRN : COL_OFF;
				BOOT_RUN:    pwr_col = i_sys_healthy ? COL_GRN : COL_RED;
				default:     pwr_col = COL_RED;
			endcase
		end
	end

	// Radio LED: transmit orange wins over the receive indication.
	always_comb
	begin
		if (act_radio_tx)
			radio_col = COL_ORG;
		else if (i_radio_link)
			radio_col = act_radio_rx ? COL_OFF : COL_GRN;
		else
			radio_col = act_radio_rx ? COL_GRN : COL_OFF;
	end

	// Serial LEDs; RS-485 has no orange, so transmit wins there.
	always_comb
	begin
		s232_col = sld_colour_t'({act_232_tx, act_232_rx});
		if (act_485_tx)
			s485_col = COL_GRN;
		else if (act_485_rx)
			s485_col = COL_RED;
		else
			s485_col = COL_OFF;
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_power_status_led <= 2'h0;
			o_radio_link_led   <= 2'h0;
			o_s232_led         <= 2'h0;
			o_s485_led         <= 2'h0;
		end
		else
		begin
			o_power_status_led <= sld_dies(pwr_col);
			o_radio_link_led   <= sld_dies(radio_col);
			o_s232_led         <= sld_dies(s232_col);
			o_s485_led         <= sld_dies(s485_col);
		end
	end

	// Digital channel LEDs, both dies together for orange.
	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_dio
			logic lit;

			always_comb
			begin
				if (!dio_dir[g])
					lit = i_digital_channel_in[g];
				else if (i_digital_channel_fail[g])
					lit = dio_fs[g] ? long_on : long_off;
				else
					lit = i_digital_channel_out[g];
			end

			always_ff @(posedge i_clk_sys or negedge i_rst_n)
			begin
				if (!i_rst_n)
				begin
					o_digital_channel_led_red[g] <= 1'b0;
					o_digital_channel_led_grn[g] <= 1'b0;
				end
				else
				begin
					o_digital_channel_led_red[g] <= lit;
					o_digital_channel_led_grn[g] <= lit;
				end
			end
		end
	endgenerate

	// Analog input LEDs and Ethernet socket LEDs.
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_analog_input_led_pos <= 2'h0;
			o_analog_input_led_neg <= 2'h0;
			o_analog_input_led_se  <= 2'h0;
		end
		else
		begin
			o_analog_input_led_pos <= i_ai_present[1:0]
				& i_ai_current_mode;
			o_analog_input_led_neg <= i_ai_present[1:0]
				& ~i_ai_current_mode;
			o_analog_input_led_se  <= i_ai_present[3:2];
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_eth_speed_led <= 1'b0;
			o_eth_link_led  <= 1'b0;
		end
		else
		begin
			o_eth_speed_led <= i_eth_link && i_eth_100m;
			o_eth_link_led  <= i_eth_link && !act_eth;
		end
	end

endmodule

// file: bench/sld_chk.sv
// Concurrent checks on the status indicator driver ports.
`timescale 1ns/1ps
`include "sld_cfg.svh"
module sld_chk #(
	parameter int unsigned TICK_CYC  = 10,
	parameter int unsigned RED_MS    = 3,
	parameter int unsigned ORANGE_MS = 4,
	parameter int unsigned FAST_MS   = 8,
	parameter int unsigned SLOW_MS   = 8
)(
	input  wire logic                   i_clk_sys,
	input  wire logic                   i_rst_n,
	input  wire logic                   i_psel,
	input  wire logic                   i_penable,
	input  wire logic                   i_pwrite,
	input  wire logic [`SLD_ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]            i_pwdata,
	input  wire logic                   o_pready,
	input  wire logic                   i_sys_fault,
	input  wire logic                   i_sys_healthy,
	input  wire logic [7:0]             i_digital_channel_in,
	input  wire logic [7:0]             i_digital_channel_out,
	input  wire logic [7:0]             i_digital_channel_fail,
	input  wire logic [3:0]             i_ai_present,
	input  wire logic                   i_eth_link,
	input  wire logic [1:0]             o_power_status_led,
	input  wire logic [7:0]             o_digital_channel_led_red,
	input  wire logic [1:0]             o_analog_input_led_pos,
	input  wire logic [1:0]             o_analog_input_led_neg,
	input  wire logic [1:0]             o_analog_input_led_se,
	input  wire logic                   o_eth_link_led
);
	localparam int unsigned R1 = (RED_MS - 1) * TICK_CYC;
	localparam int unsigned R2 = (RED_MS + 1) * TICK_CYC;
	localparam int unsigned R3 = (RED_MS + ORANGE_MS - 1) * TICK_CYC;
	localparam int unsigned R4 = (RED_MS + ORANGE_MS + FAST_MS + SLOW_MS + 1)
		* TICK_CYC;
	logic [7:0]  dir;
	logic [15:0] cyc;
	default clocking @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
		if (!i_rst_n)
			dir <= 8'h00;
		else if (i_psel && i_penable && o_pready && i_pwrite
			&& i_paddr == `SLD_REG_CTRL)
			dir <= i_pwdata[7:0];
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
		if (!i_rst_n)
			cyc <= 16'h0000;
		else if (cyc != 16'hffff)
			cyc <= cyc + 16'h0001;
	property p_red;
		cyc >= 1 && cyc < R1 |-> o_power_status_led == 2'b01;
	endproperty
	a_red: assert property (p_red)
		else $error("power LED not red at boot start");
	property p_orange;
		cyc > R2 && cyc < R3 && !$past(i_sys_fault)
			|-> o_power_status_led == 2'b11;
	endproperty
	a_orange: assert property (p_orange)
		else $error("power LED not orange in second phase");
	property p_run;
		cyc > R4 && $past(i_sys_healthy) && !$past(i_sys_fault)
			|-> o_power_status_led == 2'b10;
	endproperty
	a_run: assert property (p_run)
		else $error("power LED not green after boot");
	property p_fault;
		i_sys_fault |=> o_power_status_led == 2'b01;
	endproperty
	a_fault: assert property (p_fault)
		else $error("power LED not red on fault");
	property p_din;
		1'b1 |=> ((o_digital_channel_led_red ^ $past(i_digital_channel_in))
			& ~$past(dir)) == 8'h00;
	endproperty
	a_din: assert property (p_din)
		else $error("input channel LED differs from input");
	property p_dout;
		1'b1 |=> ((o_digital_channel_led_red ^ $past(i_digital_channel_out))
			& $past(dir) & ~$past(i_digital_channel_fail)) == 8'h00;
	endproperty
	a_dout: assert property (p_dout)
		else $error("output channel LED differs from output");
	property p_ai;
		1'b1 |=> ({o_analog_input_led_se, o_analog_input_led_pos
			| o_analog_input_led_neg} & ~$past(i_ai_present)) == 4'h0;
	endproperty
	a_ai: assert property (p_ai)
		else $error("analog LED lit without signal");
	property p_eth;
		!i_eth_link |=> !o_eth_link_led;
	endproperty
	a_eth: assert property (p_eth)
		else $error("link LED lit without link");
endmodule
bind sld_top sld_chk #(.TICK_CYC(TICK_CYC), .RED_MS(RED_MS),
	.ORANGE_MS(ORANGE_MS), .FAST_MS(FAST_MS), .SLOW_MS(SLOW_MS)) u_chk (
	.i_clk_sys, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
	.i_pwdata, .o_pready, .i_sys_fault, .i_sys_healthy,
	.i_digital_channel_in, .i_digital_channel_out, .i_digital_channel_fail,
	.i_ai_present, .i_eth_link, .o_power_status_led,
	.o_digital_channel_led_red, .o_analog_input_led_pos,
	.o_analog_input_led_neg, .o_analog_input_led_se, .o_eth_link_led);

// file: bench/sld_panel.sv
// Front-panel model that counts lit cycles of each channel LED.
`timescale 1ns/1ps
module sld_panel (
	input  wire logic            i_clk_sys,
	input  wire logic            i_clr,
	input  wire logic [7:0]      i_led,
	output logic      [7:0][7:0] o_lit
);
	always_ff @(posedge i_clk_sys)
		for (int i = 0; i < 8; i++)
			o_lit[i] <= i_clr ? 8'h00 : o_lit[i] + {7'h00, i_led[i]};
endmodule

// file: bench/tb_top.sv
// Self-checking testbench for the status indicator driver.
`timescale 1ns/1ps
module tb_top;
	logic        i_clk_sys, i_rst_n, i_psel, i_penable, i_pwrite, cnt_clr;
	logic [11:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata;
	logic        o_pready, o_pslverr, i_sys_fault, i_sys_healthy;
	logic        i_radio_link, i_radio_rx, i_radio_tx, i_s232_tx, i_s232_rx;
	logic        i_s485_tx, i_s485_rx, i_eth_link, i_eth_100m, i_eth_act;
	logic [7:0]  i_digital_channel_in, i_digital_channel_out;
	logic [7:0]  i_digital_channel_fail, o_digital_channel_led_red;
	logic [7:0]  o_digital_channel_led_grn, ex;
	logic [3:0]  i_ai_present;
	logic [1:0]  i_ai_current_mode, o_power_status_led, o_radio_link_led;
	logic [1:0]  o_s232_led, o_s485_led, o_analog_input_led_pos;
	logic [1:0]  o_analog_input_led_neg, o_analog_input_led_se;
	logic        o_eth_speed_led, o_eth_link_led;
	logic [7:0][7:0] lit;
	logic [32:0] q[$];
	logic [32:0] e;
	int          err_count = 0;
	int          check_count = 0;
	int          n;
	localparam int unsigned TB_TICK     = 10;
	localparam int unsigned TB_RED      = 3;
	localparam int unsigned TB_ORANGE   = 4;
	localparam int unsigned TB_FAST     = 8;
	localparam int unsigned TB_SLOW     = 8;
	localparam int unsigned TB_FAST_PER = 4;
	localparam int unsigned TB_SLOW_PER = 10;
	localparam int unsigned TB_STRETCH  = 3;
	sld_top #(.TICK_CYC(TB_TICK), .RED_MS(TB_RED), .ORANGE_MS(TB_ORANGE),
		.FAST_MS(TB_FAST), .SLOW_MS(TB_SLOW), .FAST_PER_MS(TB_FAST_PER),
		.SLOW_PER_MS(TB_SLOW_PER), .STRETCH_MS(TB_STRETCH)) dut (
		.i_clk_sys, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
		.i_pwdata, .o_pready, .o_prdata, .o_pslverr, .i_sys_fault,
		.i_sys_healthy, .i_radio_link, .i_radio_rx, .i_radio_tx, .i_s232_tx,
		.i_s232_rx, .i_s485_tx, .i_s485_rx, .i_digital_channel_in,
		.i_digital_channel_out, .i_digital_channel_fail, .i_ai_present,
		.i_ai_current_mode, .i_eth_link, .i_eth_100m, .i_eth_act,
		.o_power_status_led, .o_radio_link_led, .o_s232_led, .o_s485_led,
		.o_digital_channel_led_red, .o_digital_channel_led_grn,
		.o_analog_input_led_pos, .o_analog_input_led_neg,
		.o_analog_input_led_se, .o_eth_speed_led, .o_eth_link_led);
	sld_panel u_panel (.i_clk_sys, .i_clr(cnt_clr),
		.i_led(o_digital_channel_led_red), .o_lit(lit));
	initial
		i_clk_sys = 1'b0;
	always #2.5 i_clk_sys = ~i_clk_sys;
	task automatic cmp_led(input logic [7:0] g, input logic [7:0] x);
		check_count++;
		if (g !== x)
		begin
			err_count++;
			$display("mismatch at %0t: led %h expected %h", $time, g, x);
		end
	endtask
	task automatic cmp_apb(input logic [32:0] g, input logic [32:0] x);
		check_count++;
		if (g !== x)
		begin
			err_count++;
			$display("mismatch at %0t: apb %h expected %h", $time, g, x);
		end
	endtask
	task automatic wt(input int c);
		repeat (c) @(posedge i_clk_sys);
		#1;
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [32:0] x);
		@(posedge i_clk_sys);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		q.push_back(x);
		@(posedge i_clk_sys);
		i_penable <= 1'b1;
		do @(posedge i_clk_sys); while (o_pready !== 1'b1);
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge i_clk_sys)
		if (i_psel && i_penable && o_pready === 1'b1)
		begin
			e = q.pop_front();
			cmp_apb({o_pslverr, i_pwrite ? e[31:0] : o_prdata}, e);
		end
	initial
	begin
		#50000;
		err_count++;
		stop_test();
	end
	initial
	begin
		{i_rst_n, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
		{i_sys_fault, i_sys_healthy, i_radio_link, i_radio_rx} = '0;
		{i_radio_tx, i_s232_tx, i_s232_rx, i_s485_tx, i_s485_rx} = '0;
		{i_digital_channel_in, i_digital_channel_out} = '0;
		{i_digital_channel_fail, i_ai_present, i_ai_current_mode} = '0;
		{i_eth_link, i_eth_100m, i_eth_act, cnt_clr} = '0;
		void'($urandom(32'he7f0));
		repeat (3) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		i_sys_healthy <= 1'b1;
		apb(1'b0, 12'h004, 32'h0, 33'h0_0000_0001);
		apb(1'b0, 12'h000, 32'h0, 33'h0_0000_0000);
		apb(1'b0, 12'h008, 32'h0, 33'h1_0000_0000);
		apb(1'b1, 12'h004, 32'h1f, 33'h1_0000_001f);
		wt(2);
		cmp_led(o_power_status_led, 8'h01);
		wt(36);
		cmp_led(o_power_status_led, 8'h03);
		apb(1'b0, 12'h004, 32'h0, 33'h0_0000_0002);
		wt(22);
		n = 0;
		repeat (40)
		begin
			wt(1);
			n += (o_power_status_led === 2'b01);
		end
		cmp_led(n[7:0], 8'd20);
		apb(1'b0, 12'h004, 32'h0, 33'h0_0000_0004);
		wt(40);
		cmp_led(o_power_status_led, 8'h00);
		apb(1'b0, 12'h004, 32'h0, 33'h0_0000_0008);
		wt(50);
		cmp_led(o_power_status_led, 8'h02);
		wt(35);
		cmp_led(o_power_status_led, 8'h02);
		apb(1'b0, 12'h004, 32'h0, 33'h0_0000_0010);
		@(posedge i_clk_sys) i_sys_fault <= 1'b1;
		wt(3);
		cmp_led(o_power_status_led, 8'h01);
		@(posedge i_clk_sys) i_sys_fault <= 1'b0;
		i_sys_healthy <= 1'b0;
		wt(3);
		cmp_led(o_power_status_led, 8'h01);
		@(posedge i_clk_sys) i_sys_healthy <= 1'b1;
		$display("boot and power test done");
		apb(1'b1, 12'h000, 32'h050f, 33'h0_0000_050f);
		apb(1'b0, 12'h000, 32'h0, 33'h0_0000_050f);
		repeat (4)
		begin
			@(posedge i_clk_sys) i_digital_channel_in <= 8'($urandom);
			i_digital_channel_out <= 8'($urandom);
			wt(3);
			ex = (i_digital_channel_in & 8'hf0) | (i_digital_channel_out & 8'h0f);
			cmp_led(o_digital_channel_led_red, ex);
			cmp_led(o_digital_channel_led_grn, ex);
		end
		@(posedge i_clk_sys) i_digital_channel_fail <= 8'h0f;
		cnt_clr <= 1'b1;
		@(posedge i_clk_sys) cnt_clr <= 1'b0;
		wt(100);
		for (int i = 0; i < 4; i++)
			cmp_led(lit[i], i[0] ? 8'd20 : 8'd80);
		$display("digital channel test done");
		for (int i = 1; i < 4; i++)
		begin
			@(posedge i_clk_sys) {i_s232_tx, i_s232_rx} <= i[1:0];
			{i_s485_tx, i_s485_rx} <= i[1:0];
			@(posedge i_clk_sys) {i_s232_tx, i_s232_rx, i_s485_tx} <= 3'h0;
			i_s485_rx <= 1'b0;
			wt(3);
			ex = {4'h0, (i == 3) ? 2'b10 : i[1:0], i[1:0]};
			cmp_led({o_s485_led, o_s232_led}, ex);
			wt(60);
			cmp_led({o_s485_led, o_s232_led}, 8'h00);
		end
		for (int i = 0; i < 4; i++)
		begin
			@(posedge i_clk_sys) i_radio_link <= i[1];
			wt(3);
			cmp_led(o_radio_link_led, {i[1], 1'b0});
			@(posedge i_clk_sys) {i_radio_rx, i_radio_tx} <= {i[0], !i[0]};
			@(posedge i_clk_sys) {i_radio_rx, i_radio_tx} <= 2'b00;
			wt(3);
			ex = i[0] ? {!i[1], 1'b0} : 2'b11;
			cmp_led(o_radio_link_led, ex);
			wt(60);
		end
		for (int i = 0; i < 4; i++)
		begin
			@(posedge i_clk_sys) {i_ai_present, i_ai_current_mode} <= 6'($urandom);
			{i_eth_link, i_eth_100m} <= i[1:0];
			wt(3);
			ex = {i_ai_present[3:2], i_ai_present[1:0] & ~i_ai_current_mode,
				i_ai_present[1:0] & i_ai_current_mode};
			cmp_led({o_analog_input_led_se, o_analog_input_led_neg,
				o_analog_input_led_pos}, ex);
			cmp_led({o_eth_speed_led, o_eth_link_led}, {i == 3, i[1]});
			@(posedge i_clk_sys) i_eth_act <= 1'b1;
			@(posedge i_clk_sys) i_eth_act <= 1'b0;
			wt(3);
			cmp_led(o_eth_link_led, 8'h00);
			wt(60);
			cmp_led(o_eth_link_led, i[1]);
		end
		$display("link and analog test done");
		stop_test();
	end
endmodule
